// ===== logic/ssp_port.sv
// Summary of operation
// - A frame carries 4 to 16 bits, set by the data size field; the code also takes 1 to 3 bits.
// - Outgoing and incoming frames each wait in an eight-frame queue.
// - The port works either as bus master or as bus slave.
// - One master and one slave shift a frame both ways at once.
// - The master makes the serial clock and the slave takes it in.
// - Clock polarity is selectable in the SPI format, else active high.
// - The clock toggles only inside a frame and otherwise idles or floats.
// - As master the select goes active before data and drops after it, except in the pulsed format, where it drops before the first clock.
// - The active level of the select follows the frame format.
// - As slave the incoming select marks when master data is valid.
// - The master-in line is driven as slave and sampled as master.
// - An unselected slave leaves the master-in line undriven, except in the pulsed format, where it drives it until the frame ends.
// - The master-out line is driven as master and sampled as slave.
// - Pushes fill the transmit queue and pops empty the receive queue.
`timescale 1ns/1ns
`default_nettype none
module ssp_port
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire ssp_cfg_t cfg,
  input wire logic tx_push_valid,
  input wire logic [DW-1:0] tx_push_data,
  output logic tx_push_ready,
  output logic rx_pop_valid,
  input wire logic rx_pop_ready,
  output logic [DW-1:0] rx_pop_data,
  input wire logic wire_serial_clock_i,
  output logic wire_serial_clock_o,
  output logic wire_serial_clock_oe,
  input wire logic frame_sync_line_i,
  output logic frame_sync_line_o,
  output logic frame_sync_line_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  output logic busy,
  output logic overrun
);
  logic [3:0] sync1_r, sync2_r;
  logic [1:0] sync3_r;
  ssp_state_t st_r, st_nxt;
  logic [3:0] half_r;
  logic [4:0] edge_r;
  logic [DW-1:0] tx_sh_r, rx_sh_r;
  logic bit_r, sck_r, fs_r, drv_r, miso_oe_r, slv_busy_r;
  logic busy_r, overrun_r;
  logic [5:0] tog_cnt_r;
  logic tx_out_valid, rx_in_ready;
  logic [DW-1:0] tx_out_data;

  wire logic [3:0] pins_in = {mosi_i, miso_i, frame_sync_line_i,
                              wire_serial_clock_i};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= PIN_RST;
      sync2_r <= PIN_RST;
      sync3_r <= PIN_RST[1:0];
    end else if (ce) begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r[1:0];
    end
  end

  wire logic sck_s = sync2_r[PIN_SCK];
  wire logic fs_s = sync2_r[PIN_FS];
  wire logic miso_s = sync2_r[PIN_MISO];
  wire logic mosi_s = sync2_r[PIN_MOSI];
  wire logic is_spi = cfg.fmt == SSP_FMT_SPI;
  wire logic is_ssi = cfg.fmt == SSP_FMT_SSI;
  wire logic cpol_eff = is_spi & cfg.cpol;
  // The synchronous serial format drives on rising and samples on falling.
  wire logic cpha_eff = is_spi ? cfg.cpha : is_ssi;
  wire logic fs_act = is_ssi;
  wire logic mst = cfg.enable & cfg.master;
  wire logic slv = cfg.enable & ~cfg.master;
  wire logic [4:0] last_edge = {cfg.dss, 1'b1};
  wire logic tick = half_r == SCK_HALF_CYC - 4'h1;
  // Master waits for room in the receive queue so no frame is lost.
  wire logic m_start = mst & (st_r == ST_IDLE) & tx_out_valid
                       & rx_in_ready;
  wire logic fs_fall = sync3_r[PIN_FS] & ~fs_s;
  wire logic fs_rise = ~sync3_r[PIN_FS] & fs_s;
  wire logic fs_sel = fs_s == fs_act;
  wire logic s_start = slv & ~slv_busy_r & (is_ssi ? fs_rise : fs_fall);
  wire logic s_abort = slv_busy_r & ~is_ssi & ~fs_sel;
  wire logic sck_edge = sck_s ^ sync3_r[PIN_SCK];
  wire logic step = mst ? ((st_r == ST_SHIFT) & tick)
                        : (slv_busy_r & sck_edge & ~s_abort);
  wire logic lead = ~edge_r[0];
  wire logic do_sample = step & (lead ^ cpha_eff);
  wire logic do_out = step & ~(lead ^ cpha_eff);
  wire logic frame_done = step & (edge_r == last_edge);
  wire logic load = m_start | s_start;
  wire logic tx_pop = m_start | (s_start & tx_out_valid);
  // A slave with nothing queued answers with zeros.
  wire logic [DW-1:0] tx_word = tx_out_valid ? tx_out_data : '0;
  wire logic [DW-1:0] tx_align = tx_word << (DSS_MAX - cfg.dss);
  wire logic sin = mst ? miso_s : mosi_s;
  wire logic [DW-1:0] rx_word = do_sample ? {rx_sh_r[DW-2:0], sin}
                                          : rx_sh_r;
  wire logic rx_push = frame_done & rx_in_ready;
  wire logic overrun_nxt = frame_done & ~rx_in_ready;
  wire logic [DW-1:0] tx_sh_nxt =
    load ? (cpha_eff ? tx_align : {tx_align[DW-2:0], 1'b0}) :
    do_out ? {tx_sh_r[DW-2:0], 1'b0} : tx_sh_r;
  wire logic bit_nxt = load ? (cpha_eff ? bit_r : tx_align[DW-1]) :
                       do_out ? tx_sh_r[DW-1] : bit_r;
  wire logic [DW-1:0] rx_sh_nxt = load ? '0 : rx_word;
  wire logic [4:0] edge_nxt = load ? '0 :
                              step ? 5'(edge_r + 5'h1) : edge_r;
  wire logic slv_busy_nxt = s_start ? 1'b1 :
    (frame_done | s_abort | ~slv) ? 1'b0 : slv_busy_r;
  wire logic [3:0] half_nxt = (st_r == ST_IDLE || tick) ? '0
                              : 4'(half_r + 4'h1);
  // Toggles only in the shift state, so it always ends at idle level.
  wire logic sck_nxt = (st_r == ST_SHIFT) ? (sck_r ^ step)
                                          : cpol_eff;
  wire logic fs_on = (st_nxt == ST_SEL)
    | (~is_ssi & (st_nxt == ST_SHIFT || st_nxt == ST_DONE));
  wire logic fs_nxt = fs_on ? fs_act : ~fs_act;
  wire logic miso_oe_nxt = slv & (is_ssi ? slv_busy_nxt : fs_sel);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (m_start) st_nxt = ST_SEL;
      ST_SEL: if (tick) st_nxt = ST_SHIFT;
      ST_SHIFT: if (frame_done) st_nxt = ST_DONE;
      ST_DONE: if (tick) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
    if (!mst) begin
      st_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      half_r <= '0;
      edge_r <= '0;
      slv_busy_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      half_r <= half_nxt;
      edge_r <= edge_nxt;
      slv_busy_r <= slv_busy_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_sh_r <= '0;
      rx_sh_r <= '0;
      bit_r <= 1'b0;
    end else if (ce) begin
      tx_sh_r <= tx_sh_nxt;
      rx_sh_r <= rx_sh_nxt;
      bit_r <= bit_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_r <= 1'b0;
      fs_r <= FS_RST;
      drv_r <= 1'b0;
      miso_oe_r <= 1'b0;
      busy_r <= 1'b0;
      overrun_r <= 1'b0;
    end else if (ce) begin
      sck_r <= sck_nxt;
      fs_r <= fs_nxt;
      drv_r <= mst;
      miso_oe_r <= miso_oe_nxt;
      busy_r <= (st_nxt != ST_IDLE) | slv_busy_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  ssp_fifo #(.W(DW), .D(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(tx_push_valid),
    .in_ready(tx_push_ready),
    .in_data(tx_push_data),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop),
    .out_data(tx_out_data)
  );

  ssp_fifo #(.W(DW), .D(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(rx_word),
    .out_valid(rx_pop_valid),
    .out_ready(rx_pop_ready),
    .out_data(rx_pop_data)
  );

  assign wire_serial_clock_o = sck_r;
  assign wire_serial_clock_oe = drv_r;
  assign frame_sync_line_o = fs_r;
  assign frame_sync_line_oe = drv_r;
  assign mosi_o = bit_r;
  assign mosi_oe = drv_r;
  assign miso_o = bit_r;
  assign miso_oe = miso_oe_r;
  assign busy = busy_r;
  assign overrun = overrun_r;

  // Counts clock toggles written during a master frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_cnt_r <= '0;
    end else if (ce) begin
      if (m_start) begin
        tog_cnt_r <= '0;
      end else if (sck_nxt != sck_r && st_r == ST_SHIFT) begin
        tog_cnt_r <= 6'(tog_cnt_r + 6'h1);
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_sck_idle_hold: assert property (
    mst && st_r == ST_IDLE && $past(st_r) == ST_IDLE && $past(ce)
    && $stable(cfg) |-> wire_serial_clock_o == cpol_eff)
    else $error("serial clock left its idle level");
  a_fixed_clk_pol: assert property (
    mst && !is_spi && st_r == ST_IDLE && $past(st_r) == ST_IDLE
    && $past(ce) && $stable(cfg) |-> !wire_serial_clock_o)
    else $error("clock not active high outside SPI format");
  a_frame_toggles: assert property (
    mst && st_r == ST_DONE && $past(st_r) == ST_SHIFT
    |-> tog_cnt_r == 6'({1'b0, last_edge} + 6'h1))
    else $error("frame clock count does not match data size");
  a_fs_lead_sck: assert property (
    mst && !is_ssi && st_r != ST_IDLE && $stable(cfg)
    && $changed(wire_serial_clock_o) |-> frame_sync_line_o == fs_act)
    else $error("clock toggled while select inactive");
  a_fs_release: assert property (
    mst && $past(ce) && st_r == ST_IDLE && $past(st_r) == ST_DONE
    && $stable(cfg) |-> frame_sync_line_o == !fs_act)
    else $error("select not released after frame");
  a_miso_hiz: assert property (
    slv && !is_ssi && $past(ce) && $past(fs_s != fs_act)
    && $stable(cfg) |-> !miso_oe)
    else $error("unselected slave drives master-in line");
  a_one_driver: assert property (
    !(miso_oe && mosi_oe))
    else $error("both data lines driven at once");
  a_rx_room: assert property (
    mst && frame_done |-> rx_in_ready)
    else $error("master frame ended with receive queue full");

  // The master drives the clock, select and master-out lines together.
  a_oe_follow_cfg: assert property (
    $past(ce) && $stable(cfg) |-> mosi_oe == mst)
    else $error("master-out enable does not follow the mode");

  // In the pulsed format the select is gone before the first clock edge.
  a_ssi_fs_pulse: assert property (
    mst && is_ssi && st_r == ST_SHIFT && $stable(cfg)
    |-> frame_sync_line_o == !fs_act)
    else $error("pulsed select still active during shift");

  a_sck_still_sel: assert property (
    mst && st_r == ST_SEL && $past(st_r) == ST_SEL && $past(ce)
    && $stable(cfg) |-> $stable(wire_serial_clock_o))
    else $error("serial clock moved before the shift began");

  a_overrun_cause: assert property (
    overrun && $past(ce) |-> $past(!rx_in_ready))
    else $error("overrun flagged with room in the receive queue");

  a_no_slave_drive: assert property (
    $past(ce) && !$past(slv) |-> !miso_oe)
    else $error("master-in line driven while not a slave");

  a_busy_frame: assert property (
    mst && $past(ce) && st_r != ST_IDLE |-> busy)
    else $error("busy low during a master frame");
endmodule
`default_nettype wire

// ===== logic/ssp_pkg.sv
`default_nettype none
package ssp_pkg;
  localparam int DW = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] DSS_MAX = 4'hf;
  localparam int CLK_NS = 20;
  // Half period of the serial clock when master, rounded down.
  localparam int SCK_HALF_NS = 80;
  localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_HALF_NS / CLK_NS);
  localparam int PIN_SCK = 0;
  localparam int PIN_FS = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_MOSI = 3;
  // Select line idles high so the synchroniser resets to that level.
  localparam logic [3:0] PIN_RST = 4'h2;
  localparam logic FS_RST = 1'b1;

  typedef enum logic [1:0] {
    SSP_FMT_SPI = 2'h0,
    SSP_FMT_SSI = 2'h1,
    SSP_FMT_CMD = 2'h2
  } ssp_fmt_t;

  typedef struct packed {
    logic enable;
    logic master;
    ssp_fmt_t fmt;
    logic cpol;
    logic cpha;
    logic [3:0] dss;
  } ssp_cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEL = 4'h2,
    ST_SHIFT = 4'h4,
    ST_DONE = 4'h8
  } ssp_state_t;
endpackage
`default_nettype wire

// ===== logic/ssp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);
  localparam logic [AW:0] ONE = (AW+1)'(1);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r, rd_r;
  logic [AW:0] cnt_r;
  logic in_ready_r, out_valid_r;
  logic [W-1:0] out_data_r;

  wire logic push = in_valid & in_ready_r;
  wire logic pop = out_valid_r & out_ready;
  wire logic [AW-1:0] wr_nxt = push ? AW'(wr_r + 1'b1) : wr_r;
  wire logic [AW-1:0] rd_nxt = pop ? AW'(rd_r + 1'b1) : rd_r;
  wire logic [AW:0] cnt_nxt = cnt_r + (push ? ONE : '0) - (pop ? ONE : '0);
  // The head word is kept in a register so readers see a flop.
  wire logic [W-1:0] out_data_nxt =
    (push && wr_r == rd_nxt) ? in_data : mem_r[rd_nxt];

  genvar g;
  generate
    for (g = 0; g < D; g++) begin : g_entry
      always_ff @(posedge clk) begin
        if (ce && push && wr_r == AW'(g)) begin
          mem_r[g] <= in_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b1;
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (ce) begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      in_ready_r <= cnt_nxt != FULL;
      out_valid_r <= cnt_nxt != '0;
      out_data_r <= out_data_nxt;
    end
  end

  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
endmodule
`default_nettype wire

// ===== verif/ssp_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_far_model (
  input wire logic go,
  input wire logic [4:0] nbits,
  input wire logic [15:0] tx,
  input wire logic sck,
  input wire logic fs,
  input wire logic mosi,
  input wire logic miso,
  output logic sck_o,
  output logic fs_o,
  output logic mosi_o,
  output logic miso_o,
  output logic [15:0] rx
);
  logic [15:0] sh;
  logic as_m;
  initial begin
    sck_o = 1'b0;
    fs_o = 1'b1;
    mosi_o = 1'b0;
    miso_o = 1'b0;
    rx = 16'h0;
    as_m = 1'b0;
  end
  // One slave only, so its select is wired straight through.
  always @(negedge fs) if (!as_m) begin
    sh = tx << (16 - nbits);
    rx = 16'h0;
    miso_o = sh[15];
  end
  always @(posedge sck) if (!fs && !as_m) rx = {rx[14:0], mosi};
  always @(negedge sck) if (!fs && !as_m) begin
    sh = sh << 1;
    miso_o = sh[15];
  end
  // A released line shows the inverse of its last bit, not a held value.
  always @(posedge fs) if (!as_m) miso_o = ~miso_o;
  // As master the clock only runs inside the frame.
  always @(posedge go) begin
    as_m = 1'b1;
    rx = 16'h0;
    sh = tx << (16 - nbits);
    fs_o = 1'b0;
    mosi_o = sh[15];
    #160;
    repeat (nbits) begin
      #80 sck_o = 1'b1;
      rx = {rx[14:0], miso};
      #80 sck_o = 1'b0;
      sh = sh << 1;
      mosi_o = sh[15];
    end
    #160 fs_o = 1'b1;
    mosi_o = ~mosi_o;
    as_m = 1'b0;
  end
endmodule
`default_nettype wire

// ===== verif/ssp_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_port_tb;
  import ssp_pkg::*;
  logic clk, rst, go, busy, overrun;
  ssp_cfg_t cfg;
  logic tx_push_valid, tx_push_ready, rx_pop_valid, rx_pop_ready;
  logic [DW-1:0] tx_push_data, rx_pop_data;
  logic sck_o, sck_oe, fs_o, fs_oe, miso_o, miso_oe, mosi_o, mosi_oe;
  logic f_sck, f_fs, f_mosi, f_miso;
  logic [4:0] f_n;
  logic [15:0] f_tx, f_rx;
  int num_errors, tests_run, rises, cyc;
  wire logic sck_w = sck_oe ? sck_o : f_sck;
  wire logic fs_w = fs_oe ? fs_o : f_fs;
  wire logic mosi_w = mosi_oe ? mosi_o : f_mosi;
  wire logic miso_w = miso_oe ? miso_o : f_miso;
  ssp_port dut (.clk(clk), .rst(rst), .ce(1'b1), .cfg(cfg),
    .tx_push_valid(tx_push_valid), .tx_push_data(tx_push_data),
    .tx_push_ready(tx_push_ready), .rx_pop_valid(rx_pop_valid),
    .rx_pop_ready(rx_pop_ready), .rx_pop_data(rx_pop_data),
    .wire_serial_clock_i(sck_w), .wire_serial_clock_o(sck_o),
    .wire_serial_clock_oe(sck_oe), .frame_sync_line_i(fs_w),
    .frame_sync_line_o(fs_o), .frame_sync_line_oe(fs_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .busy(busy), .overrun(overrun));
  ssp_far_model far (.go(go), .nbits(f_n), .tx(f_tx), .sck(sck_w),
    .fs(fs_w), .mosi(mosi_w), .miso(miso_w), .sck_o(f_sck), .fs_o(f_fs),
    .mosi_o(f_mosi), .miso_o(f_miso), .rx(f_rx));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Counts only clock rises seen while the select is active.
  always @(posedge sck_w) if (!fs_w) rises++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  function automatic logic [15:0] msk(input int n);
    return 16'((17'h1 << n) - 17'h1);
  endfunction
  task automatic push(input logic [15:0] d);
    @(negedge clk) tx_push_valid = 1'b1;
    tx_push_data = d;
    @(posedge clk);
    while (tx_push_ready !== 1'b1) @(posedge clk);
    @(negedge clk) tx_push_valid = 1'b0;
  endtask
  task automatic pop(input logic [15:0] e);
    @(negedge clk);
    while (rx_pop_valid !== 1'b1) @(negedge clk);
    chk("rx_pop_data", e, rx_pop_data);
    rx_pop_ready = 1'b1;
    @(negedge clk) rx_pop_ready = 1'b0;
    @(negedge clk);
  endtask
  task automatic setc(input logic en, input logic m, input logic [1:0] f,
                      input logic p, input int n);
    @(negedge clk) cfg = '{en, m, ssp_fmt_t'(f), p, 1'b0, 4'(n - 1)};
    repeat (4) @(negedge clk);
  endtask
  task automatic t_idle();
    for (int f = 0; f < 3; f++) begin
      for (int p = 0; p < 2; p++) begin
        setc(1'b1, 1'b1, 2'(f), 1'(p), 8);
        chk("sck idle", 16'(f == 0 && p == 1), 16'(sck_o));
        chk("fs idle", 16'(f != 1), 16'(fs_o));
        chk("oe", 16'hd, {12'h0, sck_oe, fs_oe, miso_oe, mosi_oe});
      end
    end
    $display("end idle");
  endtask
  task automatic t_master(input int n, input logic [15:0] d, fd);
    setc(1'b1, 1'b1, 2'h0, 1'b0, n);
    f_tx = fd;
    f_n = 5'(n);
    rises = 0;
    push(d);
    repeat (4) @(negedge clk);
    while (busy === 1'b1) @(negedge clk);
    chk("rises", 16'(n), 16'(rises));
    chk("far rx", d & msk(n), f_rx & msk(n));
    pop(fd & msk(n));
    $display("end master %0d", n);
  endtask
  task automatic t_fifo();
    setc(1'b0, 1'b1, 2'h0, 1'b0, 8);
    f_tx = 16'hc3;
    f_n = 5'd8;
    for (int i = 0; i < 8; i++) push(16'(i * 17));
    chk("ready full", 16'h0, 16'(tx_push_ready));
    @(negedge clk) tx_push_valid = 1'b1;
    tx_push_data = 16'hff;
    repeat (2) @(negedge clk) tx_push_valid = 1'b0;
    setc(1'b1, 1'b1, 2'h0, 1'b0, 8);
    repeat (800) @(negedge clk);
    for (int i = 0; i < 8; i++) pop(16'hc3);
    repeat (200) @(negedge clk);
    chk("last far rx", 16'h77, f_rx);
    chk("rx empty", 16'h0, 16'(rx_pop_valid));
    $display("end fifo");
  endtask
  task automatic t_slave(input int n, input logic [15:0] d, fd);
    setc(1'b1, 1'b0, 2'h0, 1'b0, n);
    chk("unselected oe", 16'h0, {sck_oe, fs_oe, miso_oe, mosi_oe});
    push(d);
    f_tx = fd;
    f_n = 5'(n);
    go = 1'b1;
    repeat (20) @(negedge clk);
    chk("selected oe", 16'h1, 16'(miso_oe));
    go = 1'b0;
    repeat (140) @(negedge clk);
    chk("far rx", d & msk(n), f_rx & msk(n));
    pop(fd & msk(n));
    chk("released oe", 16'h0, 16'(miso_oe));
    $display("end slave");
  endtask
  initial begin
    rst = 1'b1;
    go = 1'b0;
    cfg = '0;
    tx_push_valid = 1'b0;
    tx_push_data = '0;
    rx_pop_ready = 1'b0;
    f_tx = 16'h0;
    f_n = 5'd8;
    repeat (2) @(posedge clk);
    chk("reset pins", 16'h4, {sck_o, fs_o, miso_oe, mosi_oe});
    chk("reset q", 16'h1, {busy, rx_pop_valid, tx_push_ready});
    @(negedge clk) rst = 1'b0;
    t_idle();
    t_master(4, 16'h000a, 16'h0005);
    t_master(16, 16'hb1e7, 16'h6c39);
    t_fifo();
    t_slave(12, 16'h0a5c, 16'h03e1);
    results();
  end
endmodule
`default_nettype wire
